// file: tic_top.sv
// Trigger input conditioning: debouncers, trigger hold-off, readiness flag, gain limits
`timescale 1ns/1ns
// What this block does
// - A line level change is valid only after persisting the filter duration.
// - Pulses shorter than the filter duration are dropped entirely.
// - Valid transitions come out delayed by the filter duration.
// - Filter duration is held in microseconds, zero to about one second.
// - Each of two lines has its own duration, picked by the pin choice.
// - A hold-off in microseconds sits between hardware trigger and its effect.
// - Hold-off ranges from zero to ten million microseconds.
// - A zero hold-off passes the hardware trigger through at once.
// - Standard mode delays both triggers; legacy mode only acquisition start.
// - Frame start hold-off bypassed when frame triggering is off or software.
// - Acquisition hold-off bypassed when its triggering is off or software.
// - Standard mode readiness flag shows whether a frame start is accepted.
// - Legacy mode readiness flag shows whether acquisition start is accepted.
// - The acquisition start command itself has no status indication.
// - Only gain may have its factory limits lifted, via choice and lift flag.
// - With limits lifted, gain spans the absolute hardware range.

// Register map, one 32-bit word each, unused bits read zero:
//   0x00 control
//   0x04 input filter duration in us, for the line picked by control bit 8
//   0x08 trigger hold-off in us, for the kind picked by control bit 1
//   0x0c gain, clamped to the factory or the absolute ceiling
//   0x10 status: bit 0 readiness flag, bits 3:2 debounced line levels
//   0x14 event status, write one to clear
//   0x18 event mask, same layout as the status
//   0x1c software trigger: bit 0 acquisition start, bit 1 frame start
// Any other address answers with pslverr; a write there is dropped.
//
// Control word:
//   bit 0 limited setting choice, zero selects gain
//   bit 1 trigger kind choice, zero acquisition start, one frame start
//   bit 2 legacy control mode
//   bit 3 acquisition start triggering on
//   bit 4 frame start triggering on
//   bit 5 acquisition start source is software
//   bit 6 frame start source is software
//   bit 7 readiness query choice, zero awaits the next trigger
//   bit 8 input pin choice for the filter duration
//   bit 9 factory range lift
//
// Event bits: 0 acquisition fired, 1 frame fired, 2 line 0 changed,
// 3 line 1 changed. An event in the same cycle as its clear survives.
//
// Bus timing: a write lands at the setup edge, pready and any read data
// follow one cycle later, so there are no wait states.
//
// Line timing: two synchroniser flip-flops, then the level must differ
// from the output for more than the programmed number of ticks.
// The tick phase runs free, so the extra wait is under one microsecond;
// the filtered level therefore never comes out early.
//
// Hold-off is counted in ticks as well, so an effect lands within one
// microsecond before the programmed hold-off expires. A new hardware
// trigger during a pending hold-off restarts it rather than queueing it;
// there is one counter per trigger kind and no buffer behind it.
//
// With acquisition start triggering off the block fires an acquisition
// start every cycle, standing in for internal generation.
// Frame start triggers are suppressed altogether in legacy mode.
//
// Readiness: the flag reads one while the core is idle and nothing is
// pending on the trigger kind the mode watches, frame start in standard
// mode and acquisition start in legacy mode. A query choice other than
// zero reads zero. The acquisition start command has no status of its own.
//
// Gain: writes whose low twelve bits exceed the ceiling clamp to it. The ceiling is the factory
// maximum unless the lift bit is set while gain is the chosen setting, in
// which case the absolute hardware maximum applies.
//
// Filter durations: twenty bits of microseconds, a little over one second.
// Hold-off: twenty-four bits, clamped at ten seconds on write.
//
// Limitation: the tick assumes a clock of a whole number of megahertz;
// any other clock makes every duration scale with it.
// Out of scope: acquisition mode, exposure and image data stamping.
module tic_top
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] line_in,
    input wire logic acq_hw_sel,
    input wire logic frm_hw_sel,
    input wire logic core_busy,
    output tic_pkg::tic_trig_t trig_out,
    output logic [1:0] line_valid,
    output logic [11:0] gain_value,
    output logic irq
);
    import tic_pkg::*;

    // Pin synchroniser and microsecond time base
    logic [1:0] sync1_r;
    logic [1:0] sync2_r;
    logic [4:0] tick_cnt_r;
    logic tick_r;

    // Software-visible settings
    logic [9:0] ctrl_r;
    logic [19:0] filt_r [2];
    logic [23:0] hold_acq_r;
    logic [23:0] hold_frm_r;
    logic [11:0] gain_r;

    // Debouncer and hold-off state
    tic_filt_t filt_st_r [2];
    logic [1:0] line_out_r;
    logic [1:0] line_prev_r;
    logic [23:0] cnt_acq_r;
    logic [23:0] cnt_frm_r;
    logic pend_acq_r;
    logic pend_frm_r;

    // Events and bus answer
    logic [3:0] irq_st_r;
    logic [3:0] irq_msk_r;
    tic_trig_t trig_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic irq_r;
    logic [1:0] sw_pulse_r;

    // Clamp a written word to a ceiling; the upper byte counts, so huge values clamp too
    function automatic logic [23:0] clamp24(input logic [31:0] v, input logic [23:0] mx);
        clamp24 = (v > {8'h00, mx}) ? mx : v[23:0];
    endfunction

    // Bus decode
    wire setup = psel && !penable;
    wire wr = setup && pwrite;
    wire rd = setup && !pwrite;
    wire known = (paddr == A_CTRL) || (paddr == A_FILT) || (paddr == A_HOLD)
        || (paddr == A_GAIN) || (paddr == A_STAT) || (paddr == A_IRQ_ST)
        || (paddr == A_IRQ_MSK) || (paddr == A_SWTRIG);

    // Fields of the control word
    wire line_sel = ctrl_r[C_LSEL];
    wire kind_frm = ctrl_r[C_KIND];
    wire legacy = ctrl_r[C_LEGACY];
    wire gain_pick = ctrl_r[C_PIN] == 1'b0;

    // Trigger sources: hardware comes from a debounced line
    wire acq_line = acq_hw_sel ? line_out_r[1] : line_out_r[0];
    wire frm_line = frm_hw_sel ? line_out_r[1] : line_out_r[0];
    wire acq_rise = acq_line && !line_prev_r[acq_hw_sel];
    wire frm_rise = frm_line && !line_prev_r[frm_hw_sel];

    // Hardware triggering needs the mode on and the hardware source
    wire acq_hw = ctrl_r[C_ACQ_ON] && !ctrl_r[C_ACQ_SRC];
    wire frm_hw = ctrl_r[C_FRM_ON] && !ctrl_r[C_FRM_SRC];
    wire acq_ev = acq_hw && acq_rise;
    wire frm_ev = frm_hw && frm_rise;

    // Where a hold-off applies; elsewhere the trigger passes at once
    wire frm_delay_ok = !legacy && frm_hw;
    wire acq_delay_ok = acq_hw;
    wire acq_now = (acq_ev && (!acq_delay_ok || hold_acq_r == HOLD_RST))
        || sw_pulse_r[0] || !ctrl_r[C_ACQ_ON];
    wire frm_now = (frm_ev && (!frm_delay_ok || hold_frm_r == HOLD_RST))
        || sw_pulse_r[1];

    // A pending hold-off ends on the tick that would bring it to zero
    wire acq_due = pend_acq_r && tick_r && cnt_acq_r == 24'h000001;
    wire frm_due = pend_frm_r && tick_r && cnt_frm_r == 24'h000001;
    // Either path fires; frame effects are dropped in legacy mode
    wire acq_fire = acq_now || acq_due;
    wire frm_fire = (frm_now || frm_due) && !legacy;

    // Readiness: nothing pending on the kind that the mode watches
    wire ready = ctrl_r[C_QUERY] ? 1'b0
        : (legacy ? (!core_busy && !pend_acq_r) : (!core_busy && !pend_frm_r));

    // Only gain has a lift, so other choices keep the factory cap
    wire [11:0] gain_hi = (ctrl_r[C_LIFT] && gain_pick) ? GAIN_ABS_MAX : GAIN_FACT_MAX;
    wire [11:0] gain_lo = GAIN_FACT_MIN;
    wire [11:0] gain_in = (pwdata[11:0] > gain_hi) ? gain_hi : pwdata[11:0];

    // Line events fire on each filtered change, either direction
    wire [3:0] irq_ev = {line_out_r[1] ^ line_prev_r[1], line_out_r[0] ^ line_prev_r[0],
        frm_fire, acq_fire};

    // Read data; the filter and hold-off reads follow the current choices
    wire [31:0] rd_mux = (paddr == A_CTRL) ? {22'h000000, ctrl_r}
        : (paddr == A_FILT) ? {12'h000, filt_r[line_sel]}
        : (paddr == A_HOLD) ? {8'h00, kind_frm ? hold_frm_r : hold_acq_r}
        : (paddr == A_GAIN) ? {20'h00000, gain_r}
        : (paddr == A_STAT) ? {28'h0000000, line_out_r, 1'b0, ready}
        : (paddr == A_IRQ_ST) ? {28'h0000000, irq_st_r}
        : (paddr == A_IRQ_MSK) ? {28'h0000000, irq_msk_r}
        : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_r <= 2'h0;
            sync2_r <= 2'h0;
        end
        else
        begin
            sync1_r <= line_in;
            sync2_r <= sync1_r;
        end
    end

    // Microsecond tick
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_cnt_r <= TICK_CNT_RST;
            tick_r <= 1'b0;
        end
        else
        begin
            // One tick every TICK_CYC clocks, one microsecond at the rated clock
            tick_r <= (tick_cnt_r == 5'(TICK_CYC - 1));
            tick_cnt_r <= (tick_cnt_r == 5'(TICK_CYC - 1)) ? TICK_CNT_RST : tick_cnt_r + 5'h01;
        end
    end

    // Debouncers; the counter restarts on every bounce so a short pulse never escapes.
    // A change passes one tick after the count reaches the duration, so the level
    // has stood at least that long; a zero duration passes at once.
    for (genvar i = 0; i < 2; i++)
    begin : g_line
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                filt_st_r[i] <= '0;
                line_out_r[i] <= 1'b0;
            end
            else if (sync2_r[i] == line_out_r[i])
            begin
                filt_st_r[i].cnt <= FILT_RST;
            end
            else if (filt_r[i] == FILT_RST || (tick_r && filt_st_r[i].cnt >= filt_r[i]))
            begin
                line_out_r[i] <= sync2_r[i];
                filt_st_r[i].cnt <= FILT_RST;
            end
            else if (tick_r)
            begin
                filt_st_r[i].cnt <= filt_st_r[i].cnt + 20'h00001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r <= CTRL_RST;
            filt_r[0] <= FILT_RST;
            filt_r[1] <= FILT_RST;
            hold_acq_r <= HOLD_RST;
            hold_frm_r <= HOLD_RST;
            gain_r <= GAIN_RST;
            irq_msk_r <= 4'h0;
            sw_pulse_r <= 2'h0;
        end
        else
        begin
            // A software trigger is a one-cycle pulse, nothing is latched
            sw_pulse_r <= (wr && paddr == A_SWTRIG) ? pwdata[1:0] : 2'h0;
            if (wr && paddr == A_CTRL)
                ctrl_r <= pwdata[9:0];
            if (wr && paddr == A_FILT)
                filt_r[line_sel] <= pwdata[19:0];
            if (wr && paddr == A_HOLD && !kind_frm)
                hold_acq_r <= clamp24(pwdata, HOLD_MAX_US);
            if (wr && paddr == A_HOLD && kind_frm && !legacy)
                hold_frm_r <= clamp24(pwdata, HOLD_MAX_US);
            if (wr && paddr == A_GAIN)
                gain_r <= (gain_in < gain_lo) ? gain_lo : gain_in;
            if (wr && paddr == A_IRQ_MSK)
                irq_msk_r <= pwdata[3:0];
        end
    end

    // Hold-off counters; a new trigger while one is pending restarts it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            line_prev_r <= 2'h0;
            pend_acq_r <= 1'b0;
            pend_frm_r <= 1'b0;
            cnt_acq_r <= HOLD_RST;
            cnt_frm_r <= HOLD_RST;
            trig_r <= '0;
        end
        else
        begin
            line_prev_r <= line_out_r;
            // Effects leave as one-cycle pulses from flip-flops
            trig_r.acq_trig <= acq_fire;
            trig_r.frm_trig <= frm_fire;
            // Acquisition start
            if (acq_ev && acq_delay_ok && hold_acq_r != HOLD_RST)
            begin
                pend_acq_r <= 1'b1;
                cnt_acq_r <= hold_acq_r;
            end
            else if (acq_due)
                pend_acq_r <= 1'b0;
            else if (pend_acq_r && tick_r)
                cnt_acq_r <= cnt_acq_r - 24'h000001;
            // Frame start; legacy mode drops anything pending
            if (frm_ev && frm_delay_ok && hold_frm_r != HOLD_RST)
            begin
                pend_frm_r <= 1'b1;
                cnt_frm_r <= hold_frm_r;
            end
            else if (frm_due || legacy)
                pend_frm_r <= 1'b0;
            else if (pend_frm_r && tick_r)
                cnt_frm_r <= cnt_frm_r - 24'h000001;
        end
    end

    // Sticky interrupt status; a new event wins over a write-one clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_st_r <= 4'h0;
            irq_r <= 1'b0;
            prdata_r <= 32'h00000000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            irq_st_r <= (irq_st_r & ~((wr && paddr == A_IRQ_ST) ? pwdata[3:0] : 4'h0)) | irq_ev;
            irq_r <= |(irq_st_r & irq_msk_r);
            // Answer every setup one cycle later, no wait states
            pready_r <= setup;
            pslverr_r <= setup && !known;
            if (rd)
                prdata_r <= rd_mux;
        end
    end

    // Every output is a flip-flop
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign trig_out = trig_r;
    assign line_valid = line_out_r;
    assign gain_value = gain_r;
    assign irq = irq_r;
endmodule

// file: tic_pkg.sv
// Constants, register map and carrier types for the trigger input conditioning block
package tic_pkg;
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned TICK_US = 1;
    localparam int unsigned TICK_CYC = (CLK_HZ / 1000000) * TICK_US;
    localparam logic [4:0] TICK_CNT_RST = 5'h00;

    localparam logic [19:0] FILT_MAX_US = 20'hfffff;
    localparam logic [23:0] HOLD_MAX_US = 24'h989680;
    localparam logic [19:0] FILT_RST = 20'h00000;
    localparam logic [23:0] HOLD_RST = 24'h000000;

    localparam logic [11:0] GAIN_FACT_MIN = 12'h000;
    localparam logic [11:0] GAIN_FACT_MAX = 12'h200;
    localparam logic [11:0] GAIN_ABS_MAX = 12'hfff;
    localparam logic [11:0] GAIN_RST = 12'h000;

    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_FILT = 8'h04;
    localparam logic [7:0] A_HOLD = 8'h08;
    localparam logic [7:0] A_GAIN = 8'h0c;
    localparam logic [7:0] A_STAT = 8'h10;
    localparam logic [7:0] A_IRQ_ST = 8'h14;
    localparam logic [7:0] A_IRQ_MSK = 8'h18;
    localparam logic [7:0] A_SWTRIG = 8'h1c;

    localparam int unsigned C_PIN = 0;
    localparam int unsigned C_KIND = 1;
    localparam int unsigned C_LEGACY = 2;
    localparam int unsigned C_ACQ_ON = 3;
    localparam int unsigned C_FRM_ON = 4;
    localparam int unsigned C_ACQ_SRC = 5;
    localparam int unsigned C_FRM_SRC = 6;
    localparam int unsigned C_QUERY = 7;
    localparam int unsigned C_LSEL = 8;
    localparam int unsigned C_LIFT = 9;
    localparam logic [9:0] CTRL_RST = 10'h000;

    localparam int unsigned EV_ACQ = 0;
    localparam int unsigned EV_FRM = 1;
    localparam int unsigned EV_LINE0 = 2;
    localparam int unsigned EV_LINE1 = 3;

    typedef struct packed {
        logic acq_trig;
        logic frm_trig;
    } tic_trig_t;

    typedef struct packed {
        logic [19:0] cnt;
        logic level;
    } tic_filt_t;
endpackage

// file: tic_assertions.sv
// Port-level checker for the trigger input conditioning block
`timescale 1ns/1ns
module tic_assertions
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] line_in,
    input wire tic_pkg::tic_trig_t trig_out,
    input wire logic [1:0] line_valid,
    input wire logic [11:0] gain_value
);
    import tic_pkg::*;
    logic [1:0] ctl_r;
    wire setup = psel && !penable;
    wire wr_gain = setup && pwrite && paddr == A_GAIN && pwdata[31:12] == '0;
    // Lift and choice bits; lift counts only while gain is the chosen setting
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            ctl_r <= 2'h0;
        else if (setup && pwrite && paddr == A_CTRL)
            ctl_r <= {pwdata[C_LIFT], pwdata[C_PIN]};
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_timing: assert property (setup |=> pready)
        else $error("no pready in access cycle");
    a_ready_only: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    a_unmapped_read: assert property (setup && !pwrite && paddr == 8'h20 |=> pslverr && prdata == '0)
        else $error("unmapped read not refused");
    a_swtrig_acq: assert property (setup && pwrite && paddr == A_SWTRIG && pwdata[0] |-> ##2 trig_out.acq_trig)
        else $error("software trigger late");
    a_gain_factory: assert property (wr_gain && !ctl_r[1] |=> gain_value == ($past(pwdata[11:0]) > GAIN_FACT_MAX ? GAIN_FACT_MAX : $past(pwdata[11:0])))
        else $error("gain outside factory range");
    a_gain_lifted: assert property (wr_gain && ctl_r == 2'h2 |=> gain_value == $past(pwdata[11:0]))
        else $error("lifted gain not accepted");
    a_line_rise: assert property ($rose(line_valid[0]) |-> $past(line_in[0], 2))
        else $error("line rose without pin high");
    a_line_fall: assert property ($fell(line_valid[0]) |-> !$past(line_in[0], 2))
        else $error("line fell without pin low");
endmodule
bind tic_top tic_assertions chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .line_in(line_in), .trig_out(trig_out),
    .line_valid(line_valid), .gain_value(gain_value));

// file: tic_line_src.sv
// External trigger source driving the two camera input lines
`timescale 1ns/1ns
module tic_line_src
(
    input wire logic pclk,
    output logic [1:0] line_in
);
    initial line_in = 2'h0;
    // Lines idle low; a pulse holds one line high for n cycles
    task automatic pulse(input int l, input int n);
        @(posedge pclk);
        line_in[l] <= 1'b1;
        repeat (n) @(posedge pclk);
        line_in[l] <= 1'b0;
    endtask
endmodule

// file: tic_top_test.sv
// Self-checking bench for the trigger input conditioning block
`timescale 1ns/1ns
module tic_top_test;
    import tic_pkg::*;
    typedef struct packed {logic w; logic b; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic x;} tic_row_t;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, acq_hw_sel, frm_hw_sel, core_busy, pready, pslverr, irq, er, hit;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] line_in, line_valid;
    logic [11:0] gain_value;
    tic_trig_t trig_out;
    int errors = 0;
    int checks = 0;
    int n, m, f;
    tic_row_t rows [25] = '{'{'1,'0,A_FILT,32'h3,'0,'0}, '{'1,'0,A_CTRL,32'h100,'0,'0},
        '{'1,'0,A_FILT,32'h5,'0,'0}, '{'0,'0,A_FILT,'0,32'h5,'0}, '{'1,'0,A_CTRL,'0,'0,'0},
        '{'0,'0,A_FILT,'0,32'h3,'0}, '{'1,'0,A_GAIN,32'hfff,'0,'0}, '{'0,'0,A_GAIN,'0,32'h200,'0},
        '{'1,'0,A_CTRL,32'h200,'0,'0}, '{'1,'0,A_GAIN,32'hfff,'0,'0}, '{'0,'0,A_GAIN,'0,32'hfff,'0},
        '{'1,'0,A_HOLD,32'hffffff,'0,'0}, '{'1,'0,A_CTRL,32'h2,'0,'0}, '{'1,'0,A_HOLD,'0,'0,'0},
        '{'1,'0,A_CTRL,'0,'0,'0}, '{'0,'0,A_HOLD,'0,32'h989680,'0}, '{'0,'0,A_STAT,'0,32'h1,'0},
        '{'0,'1,A_STAT,'0,'0,'0}, '{'1,'1,A_CTRL,32'h4,'0,'0}, '{'0,'1,A_STAT,'0,'0,'0},
        '{'0,'0,A_STAT,'0,32'h1,'0}, '{'1,'0,A_CTRL,32'h84,'0,'0}, '{'0,'0,A_STAT,'0,'0,'0},
        '{'0,'0,8'h20,'0,'0,'1}, '{'1,'0,8'h20,32'h5,'0,'1}};
    always #25 pclk = ~pclk;
    tic_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .line_in(line_in), .acq_hw_sel(acq_hw_sel), .frm_hw_sel(frm_hw_sel),
        .core_busy(core_busy), .trig_out(trig_out), .line_valid(line_valid),
        .gain_value(gain_value), .irq(irq));
    tic_line_src src_u (.pclk(pclk), .line_in(line_in));
    task automatic final_report;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e, input string t);
        checks++;
        if (s !== e)
        begin
            errors++;
            $display("mismatch at %0t: %s", $time, t);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask
    // Bus cycle: setup, then access held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 20);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'h0;
        if (k >= 20)
        begin
            errors++;
            final_report();
        end
    endtask
    task automatic swt(input logic [31:0] c, input logic [31:0] t);
        apb(1'b1, A_CTRL, c);
        apb(1'b1, A_SWTRIG, t);
        hit = 1'b0;
        repeat (4)
        begin
            @(posedge pclk);
            hit = hit | (t[0] ? trig_out.acq_trig : trig_out.frm_trig);
        end
    endtask
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {acq_hw_sel, frm_hw_sel, core_busy} = 3'h0;
        cyc(10);
        presetn <= 1'b1;
        foreach (rows[i])
        begin
            core_busy <= rows[i].b;
            apb(rows[i].w, rows[i].a, rows[i].d);
            chk(er, rows[i].x, "bus error");
            if (!rows[i].w)
                chk(rd, rows[i].e, "read data");
        end
        $display("register table done");
        apb(1'b1, A_HOLD, 32'h3);
        apb(1'b1, A_CTRL, 32'h18);
        // Glitches shorter than each line's filter, line1 longer than line0's filter
        fork
            src_u.pulse(0, 30);
            src_u.pulse(1, 80);
        join
        cyc(150);
        chk(line_valid, 2'h0, "glitch passed");
        {n, m, f} = {32'd0, 32'd0, 32'd99};
        fork
            src_u.pulse(0, 300);
            begin
                while (line_valid[0] !== 1'b1 && n < 200)
                begin
                    @(posedge pclk);
                    n++;
                end
                while (trig_out.acq_trig !== 1'b1 && m < 200)
                begin
                    if (trig_out.frm_trig === 1'b1 && f == 99)
                        f = m;
                    @(posedge pclk);
                    m++;
                end
            end
        join
        chk(n >= 60 && n <= 90, 1'b1, "filter latency");
        chk(f <= 2, 1'b1, "frame trigger delayed");
        chk(m >= 40 && m <= 85, 1'b1, "hold-off");
        if (n >= 200 || m >= 200)
        begin
            errors++;
            final_report();
        end
        cyc(120);
        apb(1'b0, A_IRQ_ST, 32'h0);
        chk(rd, 32'h7, "event status");
        chk(irq, 1'b0, "masked irq");
        apb(1'b1, A_IRQ_MSK, 32'h4);
        cyc(2);
        chk(irq, 1'b1, "irq raise");
        apb(1'b1, A_IRQ_ST, 32'h4);
        cyc(2);
        chk(irq, 1'b0, "irq clear");
        $display("lines and triggers done");
        swt(32'h28, 32'h1);
        chk(hit, 1'b1, "software acquisition");
        swt(32'h54, 32'h2);
        chk(hit, 1'b0, "legacy frame");
        swt(32'h50, 32'h2);
        chk(hit, 1'b1, "software frame");
        $display("software triggers done");
        presetn <= 1'b0;
        cyc(2);
        chk({trig_out, line_valid, gain_value, irq, pready}, '0, "outputs in reset");
        presetn <= 1'b1;
        apb(1'b0, A_FILT, 32'h0);
        chk(rd, 32'h0, "filter after reset");
        $display("reset done");
        final_report();
    end
endmodule
